// file: design/nsrac_pkg.sv
package nsrac_pkg;

  // register offsets of the status bank
  localparam logic [7:0] ADDR_SAT_PAIR_5_6 = 8'h8D;
  localparam logic [7:0] ADDR_SAT_PAIR_7_8 = 8'h8E;
  localparam logic [7:0] ADDR_SAT_PAIR_9_10 = 8'h8F;
  localparam logic [7:0] ADDR_SAT_PAIR_11_12 = 8'h90;
  localparam logic [7:0] ADDR_RATE_OFFSET_X = 8'h91;
  localparam logic [7:0] ADDR_RATE_OFFSET_Y = 8'h92;
  localparam logic [7:0] ADDR_RATE_OFFSET_Z = 8'h93;
  localparam logic [7:0] ADDR_OFFSET_VAR_X = 8'h94;
  localparam logic [7:0] ADDR_OFFSET_VAR_Y = 8'h95;
  localparam logic [7:0] ADDR_OFFSET_VAR_Z = 8'h96;
  localparam logic [7:0] ADDR_ATTITUDE_VAR_A = 8'h97;
  localparam logic [7:0] ADDR_ATTITUDE_VAR_B = 8'h98;
  localparam logic [7:0] ADDR_ATTITUDE_VAR_C = 8'h99;
  localparam logic [7:0] ADDR_ATTITUDE_VAR_D = 8'h9A;
  localparam logic [7:0] ADDR_BANK_FIRST = ADDR_SAT_PAIR_5_6;
  localparam logic [7:0] ADDR_BANK_LAST = ADDR_ATTITUDE_VAR_D;
  localparam int BANK_WORDS = 14;
  localparam int SAT_WORDS = 4;
  localparam int EST_WORDS = 10;

  // command addresses
  localparam logic [7:0] CMD_REPORT_FIRMWARE_VERSION = 8'hAA;
  localparam logic [7:0] CMD_SAVE_SETTINGS_NONVOLATILE = 8'hAB;
  localparam logic [7:0] CMD_RESTORE_DEFAULT_SETTINGS = 8'hAC;
  localparam logic [7:0] CMD_CALIBRATE_RATE_OFFSETS = 8'hAD;
  localparam logic [7:0] CMD_CAPTURE_HOME = 8'hAE;
  localparam logic [7:0] CMD_RESTART_ESTIMATOR = 8'hB3;

  // satellite pair field positions
  localparam int SAT_HI_ID_LSB = 24;
  localparam int SAT_HI_SNR_LSB = 16;
  localparam int SAT_LO_ID_LSB = 8;
  localparam int SAT_LO_SNR_LSB = 0;

  // values after reset and reply lengths
  localparam logic [31:0] BANK_RESET = 32'h0000_0000;
  localparam logic [2:0] RSP_LEN_WORD = 3'h4;
  localparam logic [2:0] RSP_LEN_NONE = 3'h0;

  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [31:0] data;
  } nsrac_req_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [2:0] len;
    logic err;
  } nsrac_rsp_t;

  // slot 0..7 stands for satellites 5..12
  typedef struct packed {
    logic [2:0] slot;
    logic [7:0] id;
    logic [7:0] signal_to_noise_value;
  } nsrac_sat_upd_t;

  // sel 0..9: rate offset x,y,z, offset var x,y,z, attitude var a..d
  typedef struct packed {
    logic [3:0] sel;
    logic [31:0] value;
  } nsrac_est_upd_t;

  typedef struct packed {
    logic save_settings_nonvolatile;
    logic restore_default_settings;
    logic calibrate_rate_offsets;
    logic capture_home;
    logic restart_estimator;
  } nsrac_cmd_t;

endpackage

// file: design/nsrac_top.sv
`timescale 1ns/10ps

module nsrac_top #(
  parameter int RATE_W = 16,
  parameter int POS_W = 32,
  // arbitrary revision string, ascii "0000"
  parameter logic [31:0] FW_REVISION = 32'h3030_3030
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic req_valid,
  input wire nsrac_pkg::nsrac_req_t req,
  input wire logic sat_upd_valid,
  input wire nsrac_pkg::nsrac_sat_upd_t sat_upd,
  input wire logic est_upd_valid,
  input wire nsrac_pkg::nsrac_est_upd_t est_upd,
  input wire logic [2:0][RATE_W-1:0] rate_sample,
  input wire logic [2:0][POS_W-1:0] gps_pos,
  output logic rsp_valid,
  output nsrac_pkg::nsrac_rsp_t rsp,
  output nsrac_pkg::nsrac_cmd_t cmd,
  output logic [2:0][RATE_W-1:0] rate_trim,
  output logic [2:0][POS_W-1:0] home_pos,
  output logic [2:0][POS_W-1:0] rel_pos
);

  logic [31:0] bank_reg [nsrac_pkg::BANK_WORDS];
  logic [31:0] bank_next [nsrac_pkg::BANK_WORDS];
  logic rsp_valid_reg;
  logic rsp_valid_next;
  nsrac_pkg::nsrac_rsp_t rsp_reg;
  nsrac_pkg::nsrac_rsp_t rsp_next;
  nsrac_pkg::nsrac_cmd_t cmd_reg;
  nsrac_pkg::nsrac_cmd_t cmd_next;
  logic [2:0][RATE_W-1:0] trim_reg;
  logic [2:0][RATE_W-1:0] trim_next;
  logic [2:0][POS_W-1:0] home_reg;
  logic [2:0][POS_W-1:0] home_next;
  logic [2:0][POS_W-1:0] rel_reg;
  logic [2:0][POS_W-1:0] rel_next;

  logic rd_ok;
  logic is_cmd;
  logic [7:0] rd_index;
  logic do_restore;
  logic do_restart;

  assign rd_ok = (req.addr >= nsrac_pkg::ADDR_BANK_FIRST) && (req.addr <= nsrac_pkg::ADDR_BANK_LAST);
  assign rd_index = req.addr - nsrac_pkg::ADDR_BANK_FIRST;
  assign is_cmd = (req.addr == nsrac_pkg::CMD_REPORT_FIRMWARE_VERSION) ||
                  (req.addr == nsrac_pkg::CMD_SAVE_SETTINGS_NONVOLATILE) ||
                  (req.addr == nsrac_pkg::CMD_RESTORE_DEFAULT_SETTINGS) ||
                  (req.addr == nsrac_pkg::CMD_CALIBRATE_RATE_OFFSETS) ||
                  (req.addr == nsrac_pkg::CMD_CAPTURE_HOME) ||
                  (req.addr == nsrac_pkg::CMD_RESTART_ESTIMATOR);
  assign do_restore = req_valid && !req.write && (req.addr == nsrac_pkg::CMD_RESTORE_DEFAULT_SETTINGS);
  assign do_restart = req_valid && !req.write && (req.addr == nsrac_pkg::CMD_RESTART_ESTIMATOR);

  // status words: host writes never reach them
  genvar gi;
  generate
    for (gi = 0; gi < nsrac_pkg::BANK_WORDS; gi++) begin : g_bank
      if (gi < nsrac_pkg::SAT_WORDS) begin : g_sat
        always_comb begin
          bank_next[gi] = bank_reg[gi];
          if (sat_upd_valid && (32'(sat_upd.slot) >> 1) == gi) begin
            if (!sat_upd.slot[0]) begin
              bank_next[gi][nsrac_pkg::SAT_HI_ID_LSB +: 8] = sat_upd.id;
              bank_next[gi][nsrac_pkg::SAT_HI_SNR_LSB +: 8] = sat_upd.signal_to_noise_value;
            end else begin
              bank_next[gi][nsrac_pkg::SAT_LO_ID_LSB +: 8] = sat_upd.id;
              bank_next[gi][nsrac_pkg::SAT_LO_SNR_LSB +: 8] = sat_upd.signal_to_noise_value;
            end
          end
        end
      end else begin : g_est
        always_comb begin
          bank_next[gi] = bank_reg[gi];
          // restart wins: the estimator starts from clean state that cycle
          if (do_restart) begin
            bank_next[gi] = nsrac_pkg::BANK_RESET;
          end else if (est_upd_valid && 32'(est_upd.sel) + nsrac_pkg::SAT_WORDS == gi) begin
            bank_next[gi] = est_upd.value;
          end
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          bank_reg[gi] <= nsrac_pkg::BANK_RESET;
        end else if (ce) begin
          bank_reg[gi] <= bank_next[gi];
        end
      end
    end
  endgenerate

  // request decode and reply
  always_comb begin
    rsp_valid_next = 1'b0;
    rsp_next = rsp_reg;
    cmd_next = '0;
    if (req_valid) begin
      rsp_valid_next = 1'b1;
      rsp_next.addr = req.addr;
      rsp_next.data = 32'h0000_0000;
      rsp_next.len = nsrac_pkg::RSP_LEN_NONE;
      rsp_next.err = 1'b0;
      if (req.write) begin
        rsp_next.err = 1'b1;
      end else if (rd_ok) begin
        rsp_next.data = bank_reg[rd_index[3:0]];
        rsp_next.len = nsrac_pkg::RSP_LEN_WORD;
      end else if (req.addr == nsrac_pkg::CMD_REPORT_FIRMWARE_VERSION) begin
        rsp_next.data = FW_REVISION;
        rsp_next.len = nsrac_pkg::RSP_LEN_WORD;
      end else if (!is_cmd) begin
        rsp_next.err = 1'b1;
      end
      if (!req.write) begin
        cmd_next.save_settings_nonvolatile = req.addr == nsrac_pkg::CMD_SAVE_SETTINGS_NONVOLATILE;
        cmd_next.restore_default_settings = do_restore;
        cmd_next.calibrate_rate_offsets = req.addr == nsrac_pkg::CMD_CALIBRATE_RATE_OFFSETS;
        cmd_next.capture_home = req.addr == nsrac_pkg::CMD_CAPTURE_HOME;
        cmd_next.restart_estimator = do_restart;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rsp_valid_reg <= 1'b0;
      rsp_reg <= '0;
      cmd_reg <= '0;
    end else if (ce) begin
      rsp_valid_reg <= rsp_valid_next;
      rsp_reg <= rsp_next;
      cmd_reg <= cmd_next;
    end
  end

  // per-axis trim, home and relative position
  generate
    for (gi = 0; gi < 3; gi++) begin : g_axis
      always_comb begin
        trim_next[gi] = trim_reg[gi];
        home_next[gi] = home_reg[gi];
        if (do_restore) begin
          trim_next[gi] = '0;
          home_next[gi] = '0;
        end else if (req_valid && !req.write) begin
          if (req.addr == nsrac_pkg::CMD_CALIBRATE_RATE_OFFSETS) begin
            trim_next[gi] = RATE_W'(-rate_sample[gi]);
          end
          if (req.addr == nsrac_pkg::CMD_CAPTURE_HOME) begin
            home_next[gi] = gps_pos[gi];
          end
        end
        // lags the home capture by one cycle; fine for a slowly moving fix
        rel_next[gi] = POS_W'(gps_pos[gi] - home_reg[gi]);
      end

      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          trim_reg[gi] <= '0;
          home_reg[gi] <= '0;
          rel_reg[gi] <= '0;
        end else if (ce) begin
          trim_reg[gi] <= trim_next[gi];
          home_reg[gi] <= home_next[gi];
          rel_reg[gi] <= rel_next[gi];
        end
      end
    end
  endgenerate

  assign rsp_valid = rsp_valid_reg;
  assign rsp = rsp_reg;
  assign cmd = cmd_reg;
  assign rate_trim = trim_reg;
  assign home_pos = home_reg;
  assign rel_pos = rel_reg;

endmodule // nsrac_top

// file: test/nsrac_host.sv
`timescale 1ns/10ps
module nsrac_host (
  input wire logic ref_clk,
  output logic req_valid,
  output nsrac_pkg::nsrac_req_t req
);
  nsrac_pkg::nsrac_req_t q[$];
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // idle cycles show inverted lines so a stale request never looks valid
  always @(posedge ref_clk) begin
    req_valid <= q.size() > 0;
    if (q.size() > 0) req <= q.pop_front();
    else req <= ~req;
  end
endmodule // nsrac_host

// file: test/nsrac_top_sva.sv
`timescale 1ns/10ps
module nsrac_top_sva #(
  parameter int RATE_W = 16,
  parameter int POS_W = 32,
  parameter logic [31:0] FW_REVISION = 32'h3030_3030
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic req_valid,
  input wire nsrac_pkg::nsrac_req_t req,
  input wire logic rsp_valid,
  input wire nsrac_pkg::nsrac_rsp_t rsp,
  input wire nsrac_pkg::nsrac_cmd_t cmd,
  input wire logic [2:0][RATE_W-1:0] rate_sample,
  input wire logic [2:0][RATE_W-1:0] rate_trim,
  input wire logic [2:0][POS_W-1:0] gps_pos,
  input wire logic [2:0][POS_W-1:0] home_pos
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire logic rd = req_valid && ce && !req.write;
  property p_lat; req_valid && ce |=> rsp_valid; endproperty
  a_lat: assert property (p_lat) else $error("reply missing");
  property p_once; !(req_valid && ce) |=> !rsp_valid; endproperty
  a_once: assert property (p_once) else $error("reply without request");
  property p_write; req_valid && ce && req.write |=> rsp.err && rsp.len == 3'h0 && cmd == 5'h00; endproperty
  a_write: assert property (p_write) else $error("write not refused");
  property p_fw; rd && req.addr == 8'hAA |=> rsp.addr == 8'hAA && rsp.data == FW_REVISION && rsp.len == 3'h4;
  endproperty
  a_fw: assert property (p_fw) else $error("revision reply wrong");
  property p_bank; rd && req.addr >= 8'h8D && req.addr <= 8'h9A |=> rsp.len == 3'h4 && !rsp.err
    && rsp.addr == $past(req.addr); endproperty
  a_bank: assert property (p_bank) else $error("bank read reply wrong");
  property p_cmd; rd |=> cmd == {$past(req.addr) == 8'hAB, $past(req.addr) == 8'hAC, $past(req.addr) == 8'hAD,
    $past(req.addr) == 8'hAE, $past(req.addr) == 8'hB3}; endproperty
  a_cmd: assert property (p_cmd) else $error("command pulse wrong");
  property p_trim; rd && req.addr == 8'hAD |=> rate_trim[0] == -$past(rate_sample[0])
    && rate_trim[1] == -$past(rate_sample[1]) && rate_trim[2] == -$past(rate_sample[2]); endproperty
  a_trim: assert property (p_trim) else $error("trim not loaded");
  property p_home; rd && req.addr == 8'hAE |=> home_pos == $past(gps_pos); endproperty
  a_home: assert property (p_home) else $error("home not latched");
  property p_freeze; !ce |=> $stable(rsp_valid) && $stable(rsp) && $stable(cmd) && $stable(rate_trim)
    && $stable(home_pos); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while ce low");
endmodule // nsrac_top_sva

// file: test/nsrac_top_test.sv
`timescale 1ns/10ps
module nsrac_top_test;
  logic ref_clk = 0, rstn = 0, ce = 1, sat_upd_valid = 0, est_upd_valid = 0, req_valid, rsp_valid;
  nsrac_pkg::nsrac_sat_upd_t sat_upd = '0;
  nsrac_pkg::nsrac_est_upd_t est_upd = '0;
  nsrac_pkg::nsrac_req_t req;
  nsrac_pkg::nsrac_rsp_t rsp, eq_r[$], e;
  nsrac_pkg::nsrac_cmd_t cmd, eq_c[$];
  logic [2:0][15:0] rate_sample = '0, rate_trim;
  logic [2:0][31:0] gps_pos = '0, home_pos, rel_pos;
  logic [31:0] bank[14];
  logic [7:0] cmds[5] = '{8'hAB, 8'hAC, 8'hAD, 8'hAE, 8'hB3};
  int fail_count = 0, n_checks = 0;
  always #5 ref_clk = ~ref_clk;
  nsrac_host i_host(.ref_clk, .req_valid, .req);
  nsrac_top i_dut(.ref_clk, .rstn, .ce, .req_valid, .req, .sat_upd_valid, .sat_upd, .est_upd_valid,
    .est_upd, .rate_sample, .gps_pos, .rsp_valid, .rsp, .cmd, .rate_trim, .home_pos, .rel_pos);
  task chk(string n, logic [63:0] x, logic [63:0] g);
    n_checks++;
    if (g !== x) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask
  task finish_test;
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task send(logic w, logic [7:0] a, nsrac_pkg::nsrac_rsp_t x, nsrac_pkg::nsrac_cmd_t c);
    i_host.q.push_back({w, a, $urandom()});
    eq_r.push_back(x);
    eq_c.push_back(c);
  endtask
  task rd(logic [7:0] a);
    logic ok;
    ok = a >= 8'h8D && a <= 8'h9A;
    send(1'b0, a, {a, ok ? bank[a - 8'h8D] : 32'h0, ok ? 3'h4 : 3'h0, !ok}, 5'h00);
  endtask
  task drain;
    for (int i = 0; i < 60; i++) begin
      if (eq_r.size() == 0 && i_host.q.size() == 0) return;
      @(posedge ref_clk);
    end
    chk("drain", 0, 1);
    finish_test;
  endtask
  task rd_all;
    for (int a = 8'h8D; a <= 8'h9A; a++) rd(8'(a));
    drain;
  endtask
  always @(posedge ref_clk) if (rsp_valid === 1'b1) begin
    if (eq_r.size() == 0) chk("extra", 0, 1);
    else begin
      e = eq_r.pop_front();
      chk("rsp", e, rsp);
      chk("cmd", eq_c.pop_front(), cmd);
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    chk("timeout", 0, 1);
    finish_test;
  end
  initial begin
    void'($urandom(60667));
    foreach (bank[i]) bank[i] = 32'h0;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    rd_all;
    for (int s = 0; s < 18; s++) begin
      @(posedge ref_clk);
      sat_upd_valid <= s < 8;
      est_upd_valid <= s >= 8;
      sat_upd <= {3'(s), 16'($urandom())};
      est_upd <= {4'(s - 8), $urandom()};
      #1;
      if (s < 8) bank[s / 2][((s % 2) ? 0 : 16) +: 16] = sat_upd[15:0];
      else bank[s - 4] = est_upd.value;
    end
    @(posedge ref_clk);
    {sat_upd_valid, est_upd_valid} <= 2'b00;
    send(1'b1, 8'h8F, {8'h8F, 32'h0, 3'h0, 1'b1}, 5'h00);
    rd(8'h8C);
    rd(8'h9B);
    rd_all;
    rate_sample <= 48'($urandom()) << 16 | 48'($urandom());
    gps_pos <= {$urandom(), $urandom(), $urandom()};
    @(posedge ref_clk);
    for (int i = 0; i < 5; i++) send(1'b0, cmds[i], {cmds[i], 32'h0, 3'h0, 1'b0}, 5'h10 >> i);
    drain;
    for (int k = 0; k < 3; k++) begin
      chk("trim", 16'(-rate_sample[k]), rate_trim[k]);
      chk("home", gps_pos[k], home_pos[k]);
    end
    gps_pos <= {$urandom(), $urandom(), $urandom()};
    repeat (3) @(posedge ref_clk);
    for (int k = 0; k < 3; k++) chk("rel", 32'(gps_pos[k] - home_pos[k]), rel_pos[k]);
    // updates offered while ce is low must not land in the bank
    ce <= 1'b0;
    {sat_upd_valid, est_upd_valid} <= 2'b11;
    repeat (3) @(posedge ref_clk);
    {ce, sat_upd_valid, est_upd_valid} <= 3'b100;
    for (int i = 4; i < 14; i++) bank[i] = 32'h0;
    rd_all;
    send(1'b0, 8'hAC, {8'hAC, 32'h0, 3'h0, 1'b0}, 5'h08);
    send(1'b0, 8'hAA, {8'hAA, 32'h3030_3030, 3'h4, 1'b0}, 5'h00);
    drain;
    for (int k = 0; k < 3; k++) begin
      chk("reset trim", 0, rate_trim[k]);
      chk("reset home", 0, home_pos[k]);
    end
    finish_test;
  end
endmodule // nsrac_top_test
bind nsrac_top nsrac_top_sva #(.RATE_W(RATE_W), .POS_W(POS_W), .FW_REVISION(FW_REVISION)) i_sva(.ref_clk, .rstn, .ce,
  .req_valid,
  .req, .rsp_valid, .rsp, .cmd, .rate_sample, .rate_trim, .gps_pos, .home_pos);
